// ---- rtl/pulse_measurement_unit.sv ----
// Pulse measurement unit: frequency, period and speed with an APB register file
// Summary of operation
// - Three quantities, each measured gated over an interval or continuously.
// - Gated method accumulates over the interval; value refreshes only at its end.
// - Gated method sets the done flag each measurement; clear request clears it.
// - Gated method: fewer than two rising edges in an interval report zero.
// - Gated method reports minus one until the first interval completes.
// - New interval length is taken at the next measurement, not the running one.
// - Continuous method stamps every rising edge with a microsecond timestamp.
// - Interval with pulses: time is last stamp now minus last stamp before.
// - Empty interval: time is interval end minus last pulse; one pulse assumed.
// - Estimate published only if lower frequency/speed or longer period.
// - Continuous method reports minus one until a value is published after the reference interval.
// - Continuous measurement starts at first pulse; first value needs a second.
// - Each interval after the reference one sets done with a result; cleared by handshake.
// - Separate up and down direction flags reveal a reversal within an interval.
// - Isochronous: controls taken each bus cycle, answer in the same cycle.
// - Isochronous: measurements start and end at the sampling instant.
// - Done acknowledge takes four bus cycles; use intervals of four or more.
// - Isochronous intervals are lengthened by one bus cycle.
// - Interval is n times 10 ms, or n times bus period with bounds.
// - Out of range interval flags a parameter error and blocks isochronous mode.
// - Frequency is reported in millihertz in the 32-bit value word.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module pulse_measurement_unit #(
    parameter int BASE_US = `PMU_BASE_US
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_in,
    input wire logic direction_in,
    input wire logic gate_in,
    input wire logic sample_in,
    output logic measurement_done_flag,
    output logic param_error
);
    import pmu_pkg::*;

    pmu_state_t s;
    pmu_state_t next_s;
    logic us_tick;
    logic base_tick;

    pmu_tick_gen #(
        .BASE_US(BASE_US)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .us_tick(us_tick),
        .base_tick(base_tick)
    );

    // One restoring division step: shift in the next dividend bit, subtract if it fits
    function automatic logic [112:0] div_step(input logic [48:0] rem, input logic [63:0] quo,
                                              input logic [47:0] den);
        logic [48:0] r;
        logic [63:0] q;
        r = {rem[47:0], quo[63]};
        q = {quo[62:0], 1'b0};
        if (r >= {1'b0, den})
        begin
            r = r - {1'b0, den};
            q[0] = 1'b1;
        end
        return {r, q};
    endfunction

    logic pulse_rise;
    logic sample_rise;
    logic running;
    logic unit_tick;
    logic interval_end;
    logic [45:0] span_us;
    logic free_err;
    logic iso_err;
    logic [31:0] dt;
    logic [31:0] k;
    logic start_div;
    logic [31:0] result;
    logic [3:0] live_flags;
    logic access;

    always_comb
    begin
        next_s = s;
        dt = 32'h00000000;
        k = 32'h00000000;
        start_div = 1'b0;
        result = 32'h00000000;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;

        // Pins cross into the clock domain through two flops before any use
        next_s.p_s1 = pulse_in;
        next_s.p_s2 = s.p_s1;
        next_s.p_s3 = s.p_s2;
        next_s.d_s1 = direction_in;
        next_s.d_s2 = s.d_s1;
        next_s.g_s1 = gate_in;
        next_s.g_s2 = s.g_s1;
        next_s.i_s1 = sample_in;
        next_s.i_s2 = s.i_s1;
        next_s.i_s3 = s.i_s2;
        pulse_rise = s.p_s2 & ~s.p_s3;
        sample_rise = s.i_s2 & ~s.i_s3;

        // Bounds as products so no divider is needed: floor(a/T) < n  <=>  a < n*T
        span_us = 46'(s.interval_n) * 46'(s.bus_period);
        free_err = (s.interval_n == 14'h0000) || (s.interval_n > 14'(`PMU_N_MAX));
        if (s.bus_period < 32'(`PMU_ISO_MIN_US))
        begin
            iso_err = (span_us <= 46'(`PMU_ISO_MIN_US)) || (s.interval_n > 14'(`PMU_N_MAX));
        end
        else
        begin
            iso_err = (s.interval_n == 14'h0000) || (span_us > 46'(`PMU_ISO_MAX_US));
        end
        next_s.perr = s.iso_req ? (iso_err | free_err & 1'b0) | iso_err : free_err;
        next_s.iso_act = s.iso_req & ~next_s.perr;

        if (us_tick)
        begin
            next_s.ts = s.ts + 32'h00000001;
        end

        running = s.en & s.g_s2 & ~s.perr;
        unit_tick = s.iso_act ? sample_rise : base_tick;
        interval_end = unit_tick && (s.int_cnt + 14'h0001 == s.cur_n + 14'(s.iso_act));

        case (s.state)
            ST_IDLE:
            begin
                // Isochronous measurements open on the sampling instant
                if (running && (!s.iso_act || sample_rise))
                begin
                    next_s.state = ST_RUN;
                    next_s.int_cnt = 14'h0000;
                    next_s.cur_n = s.interval_n;
                    next_s.edges = 32'h00000000;
                    // Each start reports minus one again until its first value is published
                    next_s.value = `PMU_VALUE_INIT;
                    next_s.div_cnt = 7'h00;
                    next_s.have_ref = 1'b0;
                    next_s.seen_up = 1'b0;
                    next_s.seen_dn = 1'b0;
                end
            end
            ST_RUN, ST_DIV:
            begin
                if (unit_tick)
                begin
                    next_s.int_cnt = s.int_cnt + 14'h0001;
                end
                if (interval_end)
                begin
                    next_s.int_cnt = 14'h0000;
                    next_s.cur_n = s.interval_n;
                    next_s.edges = 32'h00000000;
                    next_s.seen_up = 1'b0;
                    next_s.seen_dn = 1'b0;
                    next_s.up_flag = s.seen_up;
                    next_s.dn_flag = s.seen_dn;
                    next_s.est = 1'b0;
                    if (s.continuous)
                    begin
                        if (!s.have_ref)
                        begin
                            // First pulse only sets the reference; no value yet
                            if (s.edges != 32'h00000000)
                            begin
                                next_s.prev_ts = s.last_ts;
                                next_s.have_ref = 1'b1;
                            end
                        end
                        else if (s.edges != 32'h00000000)
                        begin
                            dt = s.last_ts - s.prev_ts;
                            k = s.edges;
                            next_s.prev_ts = s.last_ts;
                            start_div = 1'b1;
                        end
                        else
                        begin
                            dt = s.ts - s.prev_ts;
                            k = 32'h00000001;
                            next_s.est = 1'b1;
                            start_div = 1'b1;
                        end
                    end
                    else if (s.edges < 32'h00000002)
                    begin
                        next_s.value = 32'h00000000;
                        next_s.done = 1'b1;
                    end
                    else
                    begin
                        dt = s.last_ts - s.first_ts;
                        k = s.edges - 32'h00000001;
                        start_div = 1'b1;
                    end
                end
                if (pulse_rise)
                begin
                    next_s.edges = next_s.edges + 32'h00000001;
                    next_s.last_ts = s.ts;
                    if (next_s.edges == 32'h00000001)
                    begin
                        next_s.first_ts = s.ts;
                    end
                    next_s.seen_up = next_s.seen_up | s.d_s2;
                    next_s.seen_dn = next_s.seen_dn | ~s.d_s2;
                end
                if (start_div)
                begin
                    next_s.state = ST_DIV;
                    next_s.div_cnt = 7'h00;
                    next_s.rem = 49'h0;
                    // Frequency in mHz, speed in milli-rpm, period in us
                    case (s.qty)
                        QTY_PERIOD:
                        begin
                            next_s.quo = 64'(dt);
                            next_s.den = 48'(k);
                        end
                        QTY_SPEED:
                        begin
                            next_s.quo = 64'(k) * `PMU_SPEED_SCALE;
                            next_s.den = 48'(dt) * 48'(s.pulses_rev);
                        end
                        default:
                        begin
                            next_s.quo = 64'(k) * `PMU_FREQ_SCALE;
                            next_s.den = 48'(dt);
                        end
                    endcase
                end
                else if (s.state == ST_DIV)
                begin
                    {next_s.rem, next_s.quo} = div_step(s.rem, s.quo, s.den);
                    next_s.div_cnt = s.div_cnt + 7'h01;
                    if (s.div_cnt == `PMU_DIV_STEPS - 7'h01)
                    begin
                        next_s.state = ST_RUN;
                    end
                end
                if (!running)
                begin
                    next_s.state = ST_IDLE;
                end
            end
            default:
            begin
                next_s.state = ST_IDLE;
            end
        endcase

        // Quotient is final one cycle after the last step; saturate wide results
        if (s.state == ST_DIV && s.div_cnt == `PMU_DIV_STEPS && s.den != 48'h0)
        begin
            result = (s.quo[63:31] != 33'h0) ? `PMU_VALUE_SAT : s.quo[31:0];
        end
        if (s.state == ST_RUN && s.div_cnt == `PMU_DIV_STEPS)
        begin
            next_s.div_cnt = 7'h00;
            // Only a zero divisor is settled here; real quotients are compared below
            if (s.den == 48'h0)
            begin
                next_s.value = 32'h00000000;
            end
            next_s.done = 1'b1;
        end
        else if (s.state == ST_DIV && s.div_cnt == `PMU_DIV_STEPS - 7'h01)
        begin
            next_s.div_cnt = `PMU_DIV_STEPS;
        end
        if (s.state == ST_RUN && s.div_cnt == `PMU_DIV_STEPS && s.den != 48'h0)
        begin
            result = (s.quo[63:31] != 33'h0) ? `PMU_VALUE_SAT : s.quo[31:0];
            if (!s.est || (s.qty == QTY_PERIOD ? result > s.value : result < s.value))
            begin
                next_s.value = result;
            end
        end

        // Snapshot what the master sees at each sampling instant
        live_flags = {s.dn_flag, s.up_flag, s.ack, s.done};
        if (sample_rise)
        begin
            next_s.snap_value = s.value;
            next_s.snap_flags = live_flags;
        end

        // Zero-wait APB slave: answer is ready in the access phase of every transfer
        access = psel & penable & s.pready;
        if (psel && !penable)
        begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h00000000;
            case (paddr)
                `PMU_ADDR_CTRL:
                    next_s.prdata = 32'({s.clr_req, s.iso_req, s.continuous, s.qty, s.en});
                `PMU_ADDR_INTERVAL:
                    next_s.prdata = 32'(s.interval_n);
                `PMU_ADDR_BUS_PERIOD:
                    next_s.prdata = s.bus_period;
                `PMU_ADDR_PULSES_REV:
                    next_s.prdata = 32'(s.pulses_rev);
                `PMU_ADDR_STATUS:
                    next_s.prdata = 32'({s.iso_act, s.perr,
                                         s.iso_act ? s.snap_flags : live_flags});
                `PMU_ADDR_VALUE:
                    next_s.prdata = s.iso_act ? s.snap_value : s.value;
                default:
                    next_s.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite && !s.pslverr)
        begin
            case (paddr)
                `PMU_ADDR_CTRL:
                begin
                    next_s.en = pwdata[`PMU_CTRL_EN];
                    next_s.qty = quantity_t'(pwdata[`PMU_CTRL_QTY_HI:`PMU_CTRL_QTY_LO]);
                    next_s.continuous = pwdata[`PMU_CTRL_METHOD];
                    next_s.iso_req = pwdata[`PMU_CTRL_ISO];
                    next_s.clr_req = pwdata[`PMU_CTRL_CLR];
                end
                `PMU_ADDR_INTERVAL:
                    next_s.interval_n = pwdata[13:0];
                `PMU_ADDR_BUS_PERIOD:
                    next_s.bus_period = pwdata;
                `PMU_ADDR_PULSES_REV:
                    next_s.pulses_rev = pwdata[15:0];
                default:
                    next_s.pslverr = s.pslverr;
            endcase
        end

        // Clear handshake; a completion in the same cycle wins over the clear unless done is already set
        // Ack follows in one clock, well inside four bus cycles
        if (s.clr_req && !s.ack)
        begin
            next_s.ack = 1'b1;
            if (!(next_s.done && !s.done))
            begin
                next_s.done = 1'b0;
            end
        end
        else if (!s.clr_req)
        begin
            next_s.ack = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.interval_n <= `PMU_INTERVAL_RST;
            s.bus_period <= `PMU_BUS_PERIOD_RST;
            s.pulses_rev <= `PMU_PULSES_REV_RST;
            s.value <= `PMU_VALUE_INIT;
            s.snap_value <= `PMU_VALUE_INIT;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign measurement_done_flag = s.done;
    assign param_error = s.perr;
endmodule // pulse_measurement_unit
`default_nettype wire

// ---- rtl/pmu_consts.svh ----
// Constants of the pulse measurement unit: offsets, fields, resets, timing
`ifndef PMU_CONSTS_SVH
`define PMU_CONSTS_SVH

`define PMU_ADDR_CTRL 8'h00
`define PMU_ADDR_INTERVAL 8'h04
`define PMU_ADDR_BUS_PERIOD 8'h08
`define PMU_ADDR_PULSES_REV 8'h0c
`define PMU_ADDR_STATUS 8'h10
`define PMU_ADDR_VALUE 8'h14

`define PMU_CTRL_EN 0
`define PMU_CTRL_QTY_LO 1
`define PMU_CTRL_QTY_HI 2
`define PMU_CTRL_METHOD 3
`define PMU_CTRL_ISO 4
`define PMU_CTRL_CLR 5

`define PMU_STS_DONE 0
`define PMU_STS_ACK 1
`define PMU_STS_UP 2
`define PMU_STS_DN 3
`define PMU_STS_PERR 4
`define PMU_STS_ISO 5

`define PMU_INTERVAL_RST 14'h0001
`define PMU_BUS_PERIOD_RST 32'h00000000
`define PMU_PULSES_REV_RST 16'h0001
`define PMU_VALUE_INIT 32'hffffffff
`define PMU_VALUE_SAT 32'h7fffffff

`define PMU_CLK_PERIOD_NS 10
`define PMU_US_NS 1000
`define PMU_US_CYCLES (`PMU_US_NS / `PMU_CLK_PERIOD_NS)
`define PMU_BASE_US 10000
`define PMU_N_MAX 1000
`define PMU_ISO_MIN_US 10000
`define PMU_ISO_MAX_US 10000000
`define PMU_FREQ_SCALE 64'd1000000000
`define PMU_SPEED_SCALE 64'd60000000000
`define PMU_DIV_STEPS 7'd64

`endif

// ---- rtl/pmu_pkg.sv ----
// Types of the pulse measurement unit
package pmu_pkg;

    typedef enum logic [1:0] {QTY_FREQ, QTY_PERIOD, QTY_SPEED, QTY_RSVD} quantity_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DIV} meas_state_t;

    typedef struct packed {
        logic [6:0] us_cnt;
        logic [13:0] base_cnt;
        logic us_tick;
        logic base_tick;
    } tick_state_t;

    typedef struct packed {
        logic en;
        quantity_t qty;
        logic continuous;
        logic iso_req;
        logic clr_req;
        logic [13:0] interval_n;
        logic [31:0] bus_period;
        logic [15:0] pulses_rev;
        logic p_s1, p_s2, p_s3;
        logic d_s1, d_s2;
        logic g_s1, g_s2;
        logic i_s1, i_s2, i_s3;
        meas_state_t state;
        logic [31:0] ts;
        logic [13:0] int_cnt;
        logic [13:0] cur_n;
        logic [31:0] edges;
        logic [31:0] first_ts;
        logic [31:0] last_ts;
        logic [31:0] prev_ts;
        logic have_ref;
        logic seen_up;
        logic seen_dn;
        logic est;
        logic [6:0] div_cnt;
        logic [63:0] quo;
        logic [48:0] rem;
        logic [47:0] den;
        logic [31:0] value;
        logic done;
        logic ack;
        logic up_flag;
        logic dn_flag;
        logic perr;
        logic iso_act;
        logic [31:0] snap_value;
        logic [3:0] snap_flags;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pmu_state_t;

endpackage

// ---- rtl/pmu_tick_gen.sv ----
// Microsecond and base-interval enable pulses derived from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module pmu_tick_gen #(
    parameter int BASE_US = `PMU_BASE_US
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic us_tick,
    output logic base_tick
);
    import pmu_pkg::*;

    localparam logic [6:0] US_LAST = 7'(`PMU_US_CYCLES - 1);
    localparam logic [13:0] BASE_LAST = 14'(BASE_US - 1);

    tick_state_t s;
    tick_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.us_tick = 1'b0;
        next_s.base_tick = 1'b0;
        if (s.us_cnt == US_LAST)
        begin
            next_s.us_cnt = 7'h00;
            next_s.us_tick = 1'b1;
            if (s.base_cnt == BASE_LAST)
            begin
                next_s.base_cnt = 14'h0000;
                next_s.base_tick = 1'b1;
            end
            else
            begin
                next_s.base_cnt = s.base_cnt + 14'h0001;
            end
        end
        else
        begin
            next_s.us_cnt = s.us_cnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign us_tick = s.us_tick;
    assign base_tick = s.base_tick;
endmodule // pmu_tick_gen
`default_nettype wire

// ---- sim/pmu_asserts.sv ----
// Port checker for the pulse measurement unit
`timescale 1ns/1ps
`default_nettype none
module pmu_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic measurement_done_flag,
    input wire logic param_error
);
    logic acc_wr;
    logic clr_lvl;
    logic iso_lvl;
    logic exp_perr;
    assign acc_wr = psel && penable && pready && pwrite;
    // Mirrors of the written control bits, since the checker sees no internal state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            clr_lvl <= 1'h0;
            iso_lvl <= 1'h0;
            exp_perr <= 1'h0;
        end
        else if (acc_wr && paddr == 8'h00)
        begin
            clr_lvl <= pwdata[5];
            iso_lvl <= pwdata[4];
        end
        else if (acc_wr && paddr == 8'h04)
        begin
            exp_perr <= (pwdata[13:0] == 14'h0) || (pwdata[13:0] > 14'h3e8);
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_access_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("pready outside access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
        else $error("pslverr wrong for address");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    perr_range_a: assert property (acc_wr && paddr == 8'h04 && !iso_lvl |-> ##2 param_error == exp_perr)
        else $error("parameter error does not follow interval");
    perr_cause_a: assert property ($changed(param_error) |-> $past(acc_wr) || $past(acc_wr, 2))
        else $error("parameter error changed without a write");
    done_clear_a: assert property ($fell(measurement_done_flag) |-> $past(clr_lvl))
        else $error("done flag fell without clear request");
endmodule // pmu_checker
bind pulse_measurement_unit pmu_checker pmu_checker_i (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .measurement_done_flag, .param_error);
`default_nettype wire

// ---- sim/pulse_source.sv ----
// Far side model: steady encoder pulse train on the measured input
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [15:0] half_cycles,
    output logic pulse_out
);
    logic [15:0] cnt = 16'h0;
    initial pulse_out = 1'h0;
    // Held low when stopped, so no stray edge can start a measurement
    // Half periods stay far above three clocks so every edge is seen
    always @(posedge ref_clk)
    begin
        if (!run)
        begin
            pulse_out <= 1'h0;
            cnt <= 16'h0;
        end
        else if (cnt + 16'h1 >= half_cycles)
        begin
            pulse_out <= !pulse_out;
            cnt <= 16'h0;
        end
        else
            cnt <= cnt + 16'h1;
    end
endmodule // pulse_source
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench of the pulse measurement unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BASE = 10;
    localparam int IV = 2 * BASE * 100;
    localparam int SETTLE = 7000;
    typedef struct packed { logic [31:0] ctrl; logic [31:0] value; } row_t;
    typedef struct packed { logic [7:0] a; logic [31:0] d; logic err; } reg_row_t;
    typedef struct packed { logic iso; logic [31:0] n; logic err; } par_row_t;
    row_t rows [6] = '{'{32'h1, 32'h1dcd6500}, '{32'h3, 32'h2}, '{32'h5, 32'h01c9c380},
        '{32'h9, 32'h1dcd6500}, '{32'hb, 32'h2}, '{32'hd, 32'h01c9c380}};
    reg_row_t regs [7] = '{'{8'h00, 32'h0, 1'h0}, '{8'h04, 32'h1, 1'h0}, '{8'h08, 32'h0, 1'h0},
        '{8'h0c, 32'h1, 1'h0}, '{8'h10, 32'h0, 1'h0}, '{8'h14, 32'hffffffff, 1'h0},
        '{8'h18, 32'h0, 1'h1}};
    par_row_t pars [5] = '{'{1'h0, 32'h0, 1'h1}, '{1'h0, 32'h3e8, 1'h0},
        '{1'h0, 32'h3e9, 1'h1}, '{1'h1, 32'h2, 1'h1}, '{1'h1, 32'h3, 1'h0}};
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, e, run;
    logic pulse_in, direction_in, gate_in, measurement_done_flag, param_error;
    logic sample_in = 1'h0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    pulse_measurement_unit #(.BASE_US(BASE)) pulse_measurement_unit_i (.ref_clk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_in,
        .direction_in, .gate_in, .sample_in, .measurement_done_flag, .param_error);
    pulse_source pulse_source_i (.ref_clk, .run, .half_cycles(16'h64), .pulse_out(pulse_in));
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Sampling instants run slowly and freely, as a bus cycle would
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        sample_in <= cycles[9];
        if (cycles == 90000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1)
            @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(q & m, x);
    endtask
    initial
    begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        run = 1'h1;
        direction_in = 1'h1;
        gate_in = 1'h1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        apb(1'h1, 8'h04, 32'h2);
        apb(1'h1, 8'h0c, 32'h3e8);
        foreach (rows[i])
        begin
            apb(1'h1, 8'h00, 32'h0);
            apb(1'h1, 8'h00, rows[i].ctrl);
            rd(8'h14, 32'hffffffff, 32'hffffffff);
            repeat (SETTLE) @(posedge ref_clk);
            rd(8'h14, 32'hffffffff, rows[i].value);
            rd(8'h10, 32'hf, 32'h5);
            chk({31'h0, measurement_done_flag}, 32'h1);
            $display("row %0d done", i);
        end
        apb(1'h1, 8'h00, 32'h2d);
        rd(8'h10, 32'h3, 32'h2);
        chk({31'h0, measurement_done_flag}, 32'h0);
        apb(1'h1, 8'h00, 32'hd);
        rd(8'h10, 32'h2, 32'h0);
        $display("handshake done");
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h00, 32'h9);
        repeat (SETTLE) @(posedge ref_clk);
        run <= 1'h0;
        repeat (2 * IV + 200) @(posedge ref_clk);
        apb(1'h0, 8'h14, 32'h0);
        chk({31'h0, q < 32'h1dcd6500 && q != 32'h0}, 32'h1);
        $display("estimate done");
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h00, 32'h1);
        run <= 1'h1;
        repeat (14)
        begin
            repeat (500) @(posedge ref_clk);
            direction_in <= !direction_in;
        end
        rd(8'h10, 32'hc, 32'hc);
        run <= 1'h0;
        direction_in <= 1'h1;
        repeat (SETTLE) @(posedge ref_clk);
        rd(8'h14, 32'hffffffff, 32'h0);
        rd(8'h10, 32'hc, 32'h0);
        $display("reversal and silence done");
        apb(1'h1, 8'h08, 32'h1388);
        foreach (pars[i])
        begin
            apb(1'h1, 8'h00, {27'h0, pars[i].iso, 4'h1});
            apb(1'h1, 8'h04, pars[i].n);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, param_error}, {31'h0, pars[i].err});
            rd(8'h10, pars[i].iso && !pars[i].err ? 32'h10 : 32'h30, {27'h0, pars[i].err, 4'h0});
        end
        $display("parameter limits done");
        rst <= 1'h1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        foreach (regs[i])
        begin
            rd(regs[i].a, 32'hffffffff, regs[i].d);
            chk({31'h0, e}, {31'h0, regs[i].err});
        end
        $display("reset values done");
        conclude();
    end
endmodule // tb
`default_nettype wire
